// ### core/ddrio_map.vh
// Constants for the double-rate memory pin path
`ifndef DDRIO_MAP_VH
`define DDRIO_MAP_VH

// Pin group size
`define DDRIO_PINS       18
`define DDRIO_FIFO_DEPTH 16

// Width mode codes
`define DDRIO_MODE_X8    2'h0
`define DDRIO_MODE_X9    2'h1
`define DDRIO_MODE_X16   2'h2
`define DDRIO_MODE_X18   2'h3

// Active lane masks per width mode
`define DDRIO_LANES_X8   18'h000FF
`define DDRIO_LANES_X9   18'h001FF
`define DDRIO_LANES_X16  18'h0FFFF
`define DDRIO_LANES_X18  18'h3FFFF

// Link clock: four system cycles per period, quarter = one cycle
`define DDRIO_PH_W       2
`define DDRIO_PH_FIRST   2'h0
`define DDRIO_PH_Q1      2'h1
`define DDRIO_PH_HALF    2'h2
`define DDRIO_PH_LAST    2'h3

// Cycles that old pin samples stay in the synchroniser and edge history
`define DDRIO_SYNC_HIST  3

`endif

// ### core/ddrio_fifo.v
// Flip-flop FIFO between the write source and the output registers
`timescale 1ns/10ps
module ddrio_fifo #(
  parameter W     = 38,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         nrst,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // ddrio_fifo

// ### core/ddrio_path.v
// Double-rate data pin group: output mux, strobe capture, GPIO fallback
`timescale 1ns/10ps
`include "ddrio_map.vh"
module ddrio_path #(
  parameter DQW   = `DDRIO_PINS,
  parameter DEPTH = `DDRIO_FIFO_DEPTH,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire           ref_clk,
  input  wire           nrst,
  // Configuration
  input  wire           mem_en,
  input  wire [1:0]     width_mode,
  // Write stream
  input  wire           wr_valid,
  output wire           wr_ready,
  input  wire [DQW-1:0] wr_data_hi,
  input  wire [DQW-1:0] wr_data_lo,
  input  wire           wr_mask_hi,
  input  wire           wr_mask_lo,
  // Read stream
  output reg            rd_valid,
  output reg  [DQW-1:0] rd_data_hi,
  output reg  [DQW-1:0] rd_data_lo,
  // Clocks to memory
  output reg            wr_clk_out,
  output reg            mem_clk_out,
  // Data pins
  input  wire [DQW-1:0] dq_in,
  output wire [DQW-1:0] dq_out,
  output wire [DQW-1:0] dq_oe,
  // Strobe pin
  input  wire           dqs_in,
  output wire           dqs_out,
  output wire           dqs_oe,
  // Mask pin
  output reg            dm_out,
  output wire           dm_oe,
  // General-purpose use of the group, strobe at the top bit
  input  wire [DQW:0]   gpio_out,
  input  wire [DQW:0]   gpio_oe,
  output wire [DQW:0]   gpio_in
);

  localparam FW = 2 * DQW + 2;

  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  reg [`DDRIO_PINS-1:0] lane_full;
  always @* begin
    case (width_mode)
      `DDRIO_MODE_X8:  lane_full = `DDRIO_LANES_X8;
      `DDRIO_MODE_X9:  lane_full = `DDRIO_LANES_X9;
      `DDRIO_MODE_X16: lane_full = `DDRIO_LANES_X16;
      default:         lane_full = `DDRIO_LANES_X18;
    endcase
  end
  // Lanes beyond the group size never exist
  wire [DQW-1:0] lane_on = lane_full[DQW-1:0] & {DQW{mem_en}};

  // ----------------------------------------------------------------
  // Link clock generation
  // ----------------------------------------------------------------
  reg [`DDRIO_PH_W-1:0] phase;
  wire wclk = (phase == `DDRIO_PH_FIRST) | (phase == `DDRIO_PH_Q1);
  wire mclk = (phase == `DDRIO_PH_Q1) | (phase == `DDRIO_PH_HALF);
  wire load = (phase == `DDRIO_PH_LAST);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= `DDRIO_PH_FIRST;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  wire          fifo_valid;
  wire [FW-1:0] fifo_data;

  ddrio_fifo #(
    .W     (FW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_mask_hi, wr_mask_lo, wr_data_hi, wr_data_lo}),
    .out_valid (fifo_valid),
    .out_ready (load & mem_en),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Output phase registers and mux
  // ----------------------------------------------------------------
  reg [DQW-1:0] reg_a;
  reg [DQW-1:0] reg_b;
  reg           mask_a;
  reg           mask_b;
  reg           out_active;
  reg [DQW-1:0] dq_drv;
  reg           dqs_drv;
  reg           drv_on;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_a      <= {DQW{1'b0}};
      reg_b      <= {DQW{1'b0}};
      mask_a     <= 1'b0;
      mask_b     <= 1'b0;
      out_active <= 1'b0;
    end else if (load) begin
      // Both load together on the rising common clock
      if (mem_en & fifo_valid) begin
        reg_a  <= fifo_data[DQW-1+DQW:DQW];
        reg_b  <= fifo_data[DQW-1:0];
        mask_a <= fifo_data[FW-1];
        mask_b <= fifo_data[FW-2];
      end
      out_active <= mem_en & fifo_valid;
    end
  end

  // Pin stage: common clock level picks the register
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dq_drv      <= {DQW{1'b0}};
      dm_out      <= 1'b0;
      dqs_drv     <= 1'b0;
      drv_on      <= 1'b0;
      wr_clk_out  <= 1'b0;
      mem_clk_out <= 1'b0;
    end else begin
      if (wclk) begin
        dq_drv <= reg_a;
        dm_out <= mask_a;
      end else begin
        dq_drv <= reg_b;
        dm_out <= mask_b;
      end
      dqs_drv     <= mclk & out_active;
      drv_on      <= out_active & mem_en;
      wr_clk_out  <= wclk;
      mem_clk_out <= mclk;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [DQW:0] pin_s1;
  reg [DQW:0] pin_s2;
  reg         dqs_hist;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1   <= {(DQW+1){1'b0}};
      pin_s2   <= {(DQW+1){1'b0}};
      dqs_hist <= 1'b0;
    end else begin
      pin_s1   <= {dqs_in, dq_in};
      pin_s2   <= pin_s1;
      dqs_hist <= pin_s2[DQW];
    end
  end

  assign gpio_in = pin_s2;

  // ----------------------------------------------------------------
  // Read capture on strobe edges
  // ----------------------------------------------------------------
  // The memory owns the strobe during reads
  wire                        busy_now = ~mem_en | out_active | drv_on;
  reg  [`DDRIO_SYNC_HIST-1:0] busy_hist;

  // Our own strobe, or a GPIO level, lingers in the synchroniser after
  // we let go of the pin; those old samples must not look like a read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_hist <= {`DDRIO_SYNC_HIST{1'b1}};
    end else begin
      busy_hist <= {busy_hist[`DDRIO_SYNC_HIST-2:0], busy_now};
    end
  end

  wire rd_window = ~busy_now & ~(|busy_hist);
  wire dqs_rise  = rd_window & pin_s2[DQW] & ~dqs_hist;
  wire dqs_fall  = rd_window & ~pin_s2[DQW] & dqs_hist;
  reg [DQW-1:0] cap_hi;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_hi     <= {DQW{1'b0}};
      rd_data_hi <= {DQW{1'b0}};
      rd_data_lo <= {DQW{1'b0}};
      rd_valid   <= 1'b0;
    end else begin
      rd_valid <= dqs_fall;
      if (dqs_rise) begin
        cap_hi <= pin_s2[DQW-1:0] & lane_on;
      end
      if (dqs_fall) begin
        rd_data_hi <= cap_hi;
        rd_data_lo <= pin_s2[DQW-1:0] & lane_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership: memory lanes or GPIO
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < DQW; i = i + 1) begin : g_lane
      assign dq_out[i] = lane_on[i] ? dq_drv[i] : gpio_out[i];
      assign dq_oe[i]  = lane_on[i] ? drv_on : gpio_oe[i];
    end
  endgenerate

  assign dqs_out = mem_en ? dqs_drv : gpio_out[DQW];
  assign dqs_oe  = mem_en ? drv_on : gpio_oe[DQW];
  assign dm_oe   = drv_on;

endmodule // ddrio_path

// ### testbench/ddrio_path_asserts.sv
// Checker for the double-rate pin group
`timescale 1ns/10ps
module ddrio_chk #(parameter DQW = 18) (
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           nrst,
  // Watched ports
  input wire logic           mem_en,
  input wire logic [1:0]     width_mode,
  input wire logic           rd_valid,
  input wire logic           wr_clk_out,
  input wire logic           mem_clk_out,
  input wire logic           dqs_in,
  input wire logic [DQW-1:0] dq_out,
  input wire logic [DQW-1:0] dq_oe,
  input wire logic           dm_oe,
  input wire logic [DQW:0]   gpio_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_hi;
    wr_clk_out [*2];
  endsequence
  sequence s_lo;
    !wr_clk_out [*2];
  endsequence
  a_wrclk_period: assert property ($rose(wr_clk_out) |-> s_hi ##1 s_lo ##1 wr_clk_out)
    else $error("write clock period");
  a_memclk_lag: assert property (mem_clk_out == $past(wr_clk_out))
    else $error("memory clock lag");
  a_hi_hold: assert property (mem_en && dq_oe[0] && $rose(wr_clk_out) |=> $stable(dq_out))
    else $error("high phase data moved");
  a_lo_hold: assert property (mem_en && dq_oe[0] && $fell(wr_clk_out) |=> $stable(dq_out))
    else $error("low phase data moved");
  a_gpio_oe: assert property (!mem_en |-> dq_oe == gpio_oe[DQW-1:0])
    else $error("unused pin enable");
  a_x8_spare: assert property (mem_en && width_mode == 2'h0 |-> dq_oe[DQW-1:8] == gpio_oe[DQW-1:8])
    else $error("x8 spare lanes");
  a_x16_spare: assert property (mem_en && width_mode == 2'h2 |-> dq_oe[DQW-1:16] == gpio_oe[DQW-1:16])
    else $error("x16 spare lanes");
  a_mask_idle: assert property (!mem_en ##1 !mem_en |-> !dm_oe)
    else $error("mask driven while idle");
  a_rd_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid too long");
  a_rd_cause: assert property (rd_valid |-> !$past(dqs_in, 2) && $past(dqs_in, 5))
    else $error("read valid without strobe fall");
endmodule // ddrio_chk

bind ddrio_path ddrio_chk #(.DQW(DQW)) u_chk (.ref_clk, .nrst, .mem_en, .width_mode, .rd_valid,
  .wr_clk_out, .mem_clk_out, .dqs_in, .dq_out, .dq_oe, .dm_oe, .gpio_oe);

// ### testbench/ddrio_mem_model.sv
// Memory-side read model: strobe and data for one burst
`timescale 1ns/10ps
module ddrio_mem_model (
  // Strobe and data toward the pin group
  output logic        dqs,
  output logic [17:0] dq
);
  initial begin
    dqs = 1'b0;
    dq = 18'h00000;
  end
  // Strobe rests low between bursts; released data shows its inverse
  task automatic read_burst(input logic [17:0] a, input logic [17:0] b);
    dq = a;
    #12.5 dqs = 1'b1;
    #50 dq = b;
    #12.5 dqs = 1'b0;
    #50 dq = ~b;
  endtask
endmodule // ddrio_mem_model

// ### testbench/test_ddr_memory_io_path.sv
// Self-checking bench for the double-rate pin group
`timescale 1ns/10ps
`include "ddrio_map.vh"
module test_ddr_memory_io_path;
  logic        ref_clk, nrst, mem_en, wr_valid, wr_mask_hi, wr_mask_lo, m_dqs, dqs_in;
  logic        wr_ready, rd_valid, wr_clk_out, mem_clk_out, dqs_out, dqs_oe, dm_out, dm_oe;
  logic [1:0]  width_mode;
  logic [17:0] wr_data_hi, wr_data_lo, m_dq, dq_out, dq_oe, dq_in, rd_data_hi, rd_data_lo;
  logic [18:0] gpio_out, gpio_oe, gpio_in;
  int          fails = 0;
  int          n_compared = 0;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & m_dq);
  assign dqs_in = dqs_oe ? dqs_out : m_dqs;
  ddrio_path i_dut (.ref_clk, .nrst, .mem_en, .width_mode, .wr_valid, .wr_ready, .wr_data_hi,
    .wr_data_lo, .wr_mask_hi, .wr_mask_lo, .rd_valid, .rd_data_hi, .rd_data_lo, .wr_clk_out,
    .mem_clk_out, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe, .dm_out, .dm_oe,
    .gpio_out, .gpio_oe, .gpio_in);
  ddrio_mem_model i_mem (.dqs(m_dqs), .dq(m_dq));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  task push(input logic [17:0] h, input logic [17:0] l, input logic mh, input logic ml);
    {wr_data_hi, wr_data_lo, wr_mask_hi, wr_mask_lo} = {h, l, mh, ml};
    wr_valid = 1'b1;
    step;
  endtask
  task t_gpio;
    mem_en = 1'b0;
    gpio_out = 19'h2A5A5;
    gpio_oe = 19'h5F0F3;
    repeat (3) step;
    check({dq_oe, dq_out, dqs_oe, dm_oe}, {gpio_oe[17:0], gpio_out[17:0], 1'b1, 1'b0});
    check(gpio_in, {m_dqs, (gpio_oe[17:0] & gpio_out[17:0]) | (~gpio_oe[17:0] & m_dq)});
    mem_en = 1'b1;
    width_mode = `DDRIO_MODE_X8;
    step;
    check({dq_oe[17:8], dq_out[17:8]}, {gpio_oe[17:8], gpio_out[17:8]});
    width_mode = `DDRIO_MODE_X16;
    step;
    check({dq_oe[17:16], dq_out[17:16]}, {gpio_oe[17:16], gpio_out[17:16]});
  endtask
  task t_fill;
    int n;
    n = 0;
    mem_en = 1'b0;
    while (wr_ready === 1'b1 && n < 20) begin
      push(18'h0F0F0, 18'h30303, 1'b0, 1'b1);
      n++;
    end
    wr_valid = 1'b0;
    check(n, `DDRIO_FIFO_DEPTH);
    mem_en = 1'b1;
    width_mode = `DDRIO_MODE_X18;
    repeat (80) step;
    check({wr_ready, dq_oe[0]}, 2'h2);
  endtask
  task expect_word(input logic [17:0] h, input logic [17:0] l, input logic mh, input logic ml);
    check({dq_out, dm_out, wr_clk_out, mem_clk_out, dqs_out, dm_oe}, {h, mh, 4'h9});
    step;
    check({dq_out, mem_clk_out, dqs_out}, {h, 2'h3});
    step;
    check({dq_out, dm_out, wr_clk_out, mem_clk_out, dqs_out}, {l, ml, 3'h3});
    step;
    check({dq_out, mem_clk_out, dqs_out}, {l, 2'h0});
    step;
  endtask
  task t_write;
    int k;
    push(18'h2A5A5, 18'h15A5A, 1'b1, 1'b0);
    push(18'h3C3C3, 18'h03C3C, 1'b0, 1'b1);
    wr_valid = 1'b0;
    for (k = 0; k < 20 && dq_oe[0] !== 1'b1; k++)
      step;
    expect_word(18'h2A5A5, 18'h15A5A, 1'b1, 1'b0);
    expect_word(18'h3C3C3, 18'h03C3C, 1'b0, 1'b1);
    repeat (12) begin
      step;
      check(rd_valid, 1'b0);
    end
  endtask
  task wait_rd;
    int k;
    for (k = 0; k < 40 && rd_valid !== 1'b1; k++)
      step;
    check(rd_valid, 1'b1);
  endtask
  task t_read;
    logic [17:0] m;
    for (int i = 0; i < 4; i++) begin
      width_mode = i[1:0];
      m = i == 0 ? `DDRIO_LANES_X8 : i == 1 ? `DDRIO_LANES_X9 :
          i == 2 ? `DDRIO_LANES_X16 : `DDRIO_LANES_X18;
      fork
        i_mem.read_burst(18'h2D2B4, 18'h1B4C3);
        wait_rd;
      join
      repeat (4) step;
      check({rd_data_hi, rd_data_lo}, {18'h2D2B4 & m, 18'h1B4C3 & m});
    end
  endtask
  task tally_and_finish;
    $display("TB: %0d compared, %0d failed", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {nrst, mem_en, width_mode, wr_valid, wr_mask_hi, wr_mask_lo} = 7'h00;
    {wr_data_hi, wr_data_lo, gpio_out, gpio_oe} = 74'h0;
    repeat (4) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_gpio;
    t_fill;
    t_write;
    t_read;
    tally_and_finish;
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule // test_ddr_memory_io_path
